// ===== dv/pbg_board.sv
// Board model: resolves pin levels from port drive, keys and pull-ups.
// Undriven pins with no key and no pull-up toggle so that no level is assumed.
`timescale 1ns/1ps
`default_nettype none
module pbg_board (
    input wire logic       pclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_pullup_en,
    input wire logic [7:0] key,
    input wire logic [7:0] key_en,
    output logic     [7:0] pin_lvl
);
    logic [7:0] last_q;
    always_ff @(posedge pclk) last_q <= pin_lvl;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : key_en[i] ? key[i]
                : pin_pullup_en[i] ? 1'b1 : ~last_q[i];
        end
    end
endmodule : pbg_board
`default_nettype wire

// ===== dv/pbg_chk.sv
// Port checker on the APB and pin ports.
// Assumes one pclk domain, bound into every pbg_port.
`timescale 1ns/1ps
`default_nettype none
module pbg_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pwrite,
    input wire logic [7:0]  pin_in,
    input wire logic [7:0]  pin_oe_n,
    input wire logic [7:0]  pin_pullup_en,
    input wire logic        timer_ext_clock_in,
    input wire logic        irq,
    input wire logic        wake_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PULL_OFF_OUT: assert property ((pin_pullup_en & ~pin_oe_n) == 8'h00)
        else $error("pull-up on a driving pin");
    AST_READY_SETUP: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h00000000)
        else $error("refused access returned data");
    AST_WAKE_IRQ: assert property (wake_req == irq)
        else $error("wake differs from irq");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(psel && penable && pwrite)
        || $past(psel && penable && pwrite, 2))
        else $error("irq dropped without a write");
    AST_PIN5_TIMER: assert property ($past(presetn) |-> timer_ext_clock_in == $past(pin_in[5]))
        else $error("timer clock input not pin 5");
endmodule : pbg_chk
bind pbg_port pbg_chk pbg_chk_inst (.*);
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for pbg_port over APB with a board model.
// Assumes the registered zero-wait answer of the port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pbg_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cap_o = 0, cap_d = 0, cmp_o = 0, cmp_e = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, cap_in, tck, kbd, irq, wake;
    logic [7:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, key = 8'ha0, key_en = 8'hff;
    int n_fail = 0, checks = 0;
    logic [20:0] rows [9] = '{{PBG_OFF_PINS, 8'ha0, 1'b0}, {PBG_OFF_DIR, 8'hff, 1'b0},
        {PBG_OFF_LATCH, 8'h00, 1'b0}, {PBG_OFF_ICM, 8'h01, 1'b0}, {PBG_OFF_ICS, 8'h80, 1'b0},
        {PBG_OFF_ANALOG, 8'h1f, 1'b0}, {PBG_OFF_IRQ_MASK, 8'h00, 1'b0},
        {PBG_OFF_ALTCFG, 8'h01, 1'b0}, {12'h020, 8'h00, 1'b1}};
    always #50 pclk = ~pclk;
    pbg_port pbg_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .second_capture_unit_out(cap_o),
        .second_capture_unit_drive(cap_d), .second_capture_unit_in(cap_in),
        .comparator_one_out(cmp_o), .comparator_one_out_en(cmp_e), .timer_ext_clock_in(tck),
        .keyboard_change_in(kbd), .irq(irq), .wake_req(wake));
    pbg_board pbg_board_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .key(key), .key_en(key_en), .pin_lvl(pin_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never re-raises psel in this time step
        @(posedge pclk);
        if (n >= 50) chk(1'b0, 1'b1);
    endtask : apb
    task automatic stop_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    initial begin
        #1000000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge pclk);
        chk(pin_oe_n, 8'hff);
        chk(pin_pullup_en, 8'h00);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(1'b0, rows[i][20:9], 32'h0);
            chk(r, {24'h0, rows[i][8:1]});
            chk(e, rows[i][0]);
        end
        $display("test reset values done");
        apb(1'b1, PBG_OFF_LATCH, 32'h5a);
        apb(1'b1, PBG_OFF_DIR, 32'hcf);
        apb(1'b1, PBG_OFF_ICS, 32'h00);
        apb(1'b1, PBG_OFF_ANALOG, 32'h00);
        key_en <= 8'hf0;
        repeat (3) @(posedge pclk);
        chk(pin_oe_n, 8'hcf);
        chk(pin_out & 8'h30, 8'h10);
        chk(pin_pullup_en, 8'hcf);
        apb(1'b0, PBG_OFF_LATCH, 32'h0);
        chk(r, 32'h5a);
        apb(1'b0, PBG_OFF_PINS, 32'h0);
        chk(r, 32'h9f);
        $display("test direction and pull-ups done");
        key_en <= 8'hff;
        apb(1'b1, PBG_OFF_DIR, 32'hff);
        apb(1'b1, PBG_OFF_IRQ_MASK, 32'h01);
        repeat (3) @(posedge pclk);
        apb(1'b0, PBG_OFF_PINS, 32'h0);
        apb(1'b1, PBG_OFF_ICM, 32'h01);
        key <= 8'ha8;
        repeat (4) @(posedge pclk);
        chk(irq, 1'b0);
        key <= 8'he8;
        repeat (4) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, PBG_OFF_ICM, 32'h01);
        apb(1'b0, PBG_OFF_ICM, 32'h0);
        chk(r, 32'h01);
        apb(1'b0, PBG_OFF_PINS, 32'h0);
        apb(1'b1, PBG_OFF_ICM, 32'h01);
        repeat (3) @(posedge pclk);
        chk({irq, wake}, 2'b00);
        $display("test change interrupt done");
        key <= 8'hc8;
        repeat (3) @(posedge pclk);
        chk(kbd, 1'b1);
        chk(tck, 1'b0);
        cmp_o <= 1'b1;
        cmp_e <= 1'b1;
        cap_o <= 1'b0;
        cap_d <= 1'b1;
        apb(1'b1, PBG_OFF_ALTCFG, 32'h00);
        repeat (3) @(posedge pclk);
        chk(pin_oe_n, 8'hd7);
        chk(pin_out, 8'h72);
        chk(pin_pullup_en, 8'hd7);
        chk({tck, cap_in}, 2'b10);
        $display("test shared pins done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire

// ===== rtl/pbg_pkg.sv
// Package for the eight-pin port with change interrupt.
// Assumes a 32-bit APB slave with word-aligned registers.
package pbg_pkg;
    localparam int          PBG_WIDTH         = 8;
    localparam logic [11:0] PBG_OFF_PINS      = 12'h000;
    localparam logic [11:0] PBG_OFF_DIR       = 12'h004;
    localparam logic [11:0] PBG_OFF_LATCH     = 12'h008;
    localparam logic [11:0] PBG_OFF_ICM       = 12'h00c;
    localparam logic [11:0] PBG_OFF_ICS       = 12'h010;
    localparam logic [11:0] PBG_OFF_ANALOG    = 12'h014;
    localparam logic [11:0] PBG_OFF_IRQ_MASK  = 12'h018;
    localparam logic [11:0] PBG_OFF_ALTCFG    = 12'h01c;
    localparam int          PBG_CHG_BIT       = 0;
    localparam int          PBG_PULLUP_BIT    = 7;
    localparam int          PBG_ALT_BIT       = 0;
    localparam int          PBG_CHG_LO        = 4;
    localparam int          PBG_CAP_PIN       = 3;
    localparam int          PBG_TMR_PIN       = 5;
    localparam logic [7:0]  PBG_DIR_RST       = 8'hff;
    localparam logic [7:0]  PBG_LATCH_RST     = 8'h00;
    localparam logic [7:0]  PBG_ANALOG_RST    = 8'h1f;
    localparam logic        PBG_PULLUP_N_RST  = 1'b1;
    localparam logic        PBG_ALT_RST       = 1'b1;
endpackage : pbg_pkg

// ===== rtl/pbg_port.sv
// Eight-pin bidirectional port with direction, latch, pull-ups and change interrupt.
// Assumes an APB master on pclk and pins already synchronous to pclk.
// Functional notes
// - Eight pins, each individually input or output.
// - Direction bit 1 tri-states the pin driver; pin is an input.
// - Direction bit 0 drives the pin with its latch bit.
// - Latch register reads return latch contents, not pin levels.
// - Clearing shared active-low bit 7 of second control enables all pull-ups.
// - Pull-up is forced off on any pin configured as output.
// - Pull-ups are disabled after reset.
// - After reset pins 4..0 analog reading 0; pins 7..5 digital inputs.
// - Only pins 7..4 compared; output pins excluded.
// - Inputs compared with snapshot from last port access; ORed into flag bit 0.
// - Change interrupt can wake the device from sleep and idle.
// - Persistent mismatch keeps setting flag; port read refreshes snapshot.
// - Pin 3 carries the second capture unit when alt select is 0.
// - Pin 5 also feeds timer clock in and carries comparator one out.
`timescale 1ns/1ps
`default_nettype none
module pbg_port
    import pbg_pkg::*;
#(
    parameter int WIDTH = PBG_WIDTH
) (
    // APB
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pins
    input  wire logic [WIDTH-1:0]  pin_in,
    output logic      [WIDTH-1:0]  pin_out,
    output logic      [WIDTH-1:0]  pin_oe_n,
    output logic      [WIDTH-1:0]  pin_pullup_en,
    // Shared functions
    input  wire logic              second_capture_unit_out,
    input  wire logic              second_capture_unit_drive,
    output logic                   second_capture_unit_in,
    input  wire logic              comparator_one_out,
    input  wire logic              comparator_one_out_en,
    output logic                   timer_ext_clock_in,
    output logic                   keyboard_change_in,
    // Status
    output logic                   irq,
    output logic                   wake_req
);

    // Pin map, nibble split and shared-pin taps are laid out for eight pins only
    if (WIDTH != 8) begin : g_width_check
        $error("pbg_port supports WIDTH of 8 only");
    end

    // Number of pins that take part in change detection
    localparam int CHG_N = WIDTH - PBG_CHG_LO;

    // Register state
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] analog_q;
    logic [WIDTH-1:0] snap_q;
    logic             pullup_n_q;
    logic             flag_q;
    logic             mask_q;
    logic             alt_q;

    // Pin path
    logic [WIDTH-1:0] dig_in;
    logic [WIDTH-1:0] drive_val;
    logic [WIDTH-1:0] drive_oe_n;
    logic [WIDTH-1:0] pull_d;
    logic             cap_drive;
    logic             cmp_drive;

    // Change detection
    logic [CHG_N-1:0] mismatch;
    logic             change;

    // Bus decode
    logic             acc;
    logic             wr;
    logic             setup;
    logic             port_touch;
    logic             mapped;
    logic [31:0]      rdata_d;
    logic             wr_dir;
    logic             wr_latch;
    logic             wr_analog;
    logic             wr_alt;
    logic             wr_ctl2;
    logic             wr_mask;
    logic             clr_flag;

    assign acc        = psel && penable;
    assign wr         = acc && pwrite;
    assign setup      = psel && !penable;
    assign port_touch = acc && (paddr == PBG_OFF_PINS);

    // Writes land at the access edge, where pready is already high
    assign wr_dir    = wr && (paddr == PBG_OFF_DIR);
    // A port write goes to the latch; the pins follow only where driven
    assign wr_latch  = wr && (paddr == PBG_OFF_LATCH || paddr == PBG_OFF_PINS);
    assign wr_analog = wr && (paddr == PBG_OFF_ANALOG);
    assign wr_alt    = wr && (paddr == PBG_OFF_ALTCFG);
    assign wr_ctl2   = wr && (paddr == PBG_OFF_ICS);
    assign wr_mask   = wr && (paddr == PBG_OFF_IRQ_MASK);
    assign clr_flag  = wr && (paddr == PBG_OFF_ICM) && pwdata[PBG_CHG_BIT];

    // Peripherals take their pin only while they ask to drive it
    assign cap_drive = !alt_q && second_capture_unit_drive;
    assign cmp_drive = comparator_one_out_en;

    // Per-pin drive, pull-up and sampled level
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        // Analog pins read as zero
        assign dig_in[i] = pin_in[i] & ~analog_q[i];
        if (i == PBG_CAP_PIN) begin : g_cap
            assign drive_val[i]  = cap_drive ? second_capture_unit_out : latch_q[i];
            assign drive_oe_n[i] = cap_drive ? 1'b0 : dir_q[i];
        end else if (i == PBG_TMR_PIN) begin : g_cmp
            assign drive_val[i]  = cmp_drive ? comparator_one_out : latch_q[i];
            assign drive_oe_n[i] = cmp_drive ? 1'b0 : dir_q[i];
        end else begin : g_plain
            assign drive_val[i]  = latch_q[i];
            assign drive_oe_n[i] = dir_q[i];
        end
        // Taken from the final driver state, so a peripheral override drops it too
        assign pull_d[i] = !pullup_n_q && drive_oe_n[i];
    end

    // Change detect on the upper pins; an output pin never mismatches
    for (genvar k = 0; k < CHG_N; k++) begin : g_chg
        assign mismatch[k] = (dig_in[PBG_CHG_LO+k] ^ snap_q[PBG_CHG_LO+k])
                             && dir_q[PBG_CHG_LO+k];
    end
    assign change = |mismatch;

    // Direction register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= PBG_DIR_RST;
        end else if (wr_dir) begin
            dir_q <= pwdata[WIDTH-1:0];
        end
    end

    // Output latch, written through port or latch address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= PBG_LATCH_RST;
        end else if (wr_latch) begin
            latch_q <= pwdata[WIDTH-1:0];
        end
    end

    // Analog select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_q <= PBG_ANALOG_RST;
        end else if (wr_analog) begin
            analog_q <= pwdata[WIDTH-1:0];
        end
    end

    // Alternate pin select for the second capture unit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_q <= PBG_ALT_RST;
        end else if (wr_alt) begin
            alt_q <= pwdata[PBG_ALT_BIT];
        end
    end

    // Shared active-low pull-up control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_n_q <= PBG_PULLUP_N_RST;
        end else if (wr_ctl2) begin
            pullup_n_q <= pwdata[PBG_PULLUP_BIT];
        end
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 1'b0;
        end else if (wr_mask) begin
            mask_q <= pwdata[PBG_CHG_BIT];
        end
    end

    // Snapshot taken on any port access
    // Writes refresh it as well, so either access ends the mismatch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_q <= '0;
        end else if (port_touch) begin
            snap_q <= dig_in;
        end
    end

    // Sticky change flag
    // A persistent mismatch keeps setting it, and the set wins over a clear in the same cycle
    // Setting is held off in the cycle of a port access, whose snapshot ends the mismatch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (change && !port_touch) begin
            flag_q <= 1'b1;
        end else if (clr_flag) begin
            flag_q <= 1'b0;
        end
    end

    // Pin drive value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
        end else begin
            pin_out <= drive_val;
        end
    end

    // Pin output enable, low while driving
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe_n <= '1;
        end else begin
            pin_oe_n <= drive_oe_n;
        end
    end

    // Weak pull-ups
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_pullup_en <= '0;
        end else begin
            pin_pullup_en <= pull_d;
        end
    end

    // Level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= flag_q && mask_q;
        end
    end

    // Wake request, same level as irq; the power controller watches this one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= flag_q && mask_q;
        end
    end

    // Capture input from pin 3 while the alternate select is clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_capture_unit_in <= 1'b0;
        end else begin
            second_capture_unit_in <= !alt_q && dig_in[PBG_CAP_PIN];
        end
    end

    // Timer external clock from pin 5
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_ext_clock_in <= 1'b0;
        end else begin
            timer_ext_clock_in <= dig_in[PBG_TMR_PIN];
        end
    end

    // Keyboard change on pin 5
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keyboard_change_in <= 1'b0;
        end else begin
            keyboard_change_in <= mismatch[PBG_TMR_PIN-PBG_CHG_LO];
        end
    end

    // Read data; unmapped offsets read zero and are refused
    always_comb begin
        mapped  = 1'b1;
        rdata_d = 32'h0000_0000;
        case (paddr)
            PBG_OFF_PINS:     rdata_d[WIDTH-1:0] = dig_in;
            PBG_OFF_DIR:      rdata_d[WIDTH-1:0] = dir_q;
            PBG_OFF_LATCH:    rdata_d[WIDTH-1:0] = latch_q;
            PBG_OFF_ICM:      rdata_d[PBG_CHG_BIT] = flag_q;
            PBG_OFF_ICS:      rdata_d[PBG_PULLUP_BIT] = pullup_n_q;
            PBG_OFF_ANALOG:   rdata_d[WIDTH-1:0] = analog_q;
            PBG_OFF_IRQ_MASK: rdata_d[PBG_CHG_BIT] = mask_q;
            PBG_OFF_ALTCFG:   rdata_d[PBG_ALT_BIT] = alt_q;
            default:          mapped = 1'b0;
        endcase
    end

    // No wait state: answer registered from the setup cycle
    // Keeps psel and paddr off any path to pready, without adding a cycle to the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Refusal of unmapped offsets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !mapped;
        end
    end

    // Read data stands only in the answer cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= (setup && !pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

endmodule : pbg_port
`default_nettype wire
